// ==== dli_interp.v ====
// dual lane interpolator datapath with its register port
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "dli_map.vh"
module dli_interp
#(
    parameter HAS_CLAMP = 0     // 1 for the second interpolator
)
(
    input  wire                   i_ref_clk,
    input  wire                   i_reset_n,
    input  wire [`DLI_ADDR_W-1:0] i_addr,
    input  wire [31:0]            i_wr_data,
    input  wire                   i_wr_en,
    input  wire                   i_rd_en,
    output reg  [31:0]            o_rd_data
);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    reg  [31:0] lane_zero_accumulator;
    reg  [31:0] lane_one_accumulator;
    reg  [31:0] lane_zero_offset;
    reg  [31:0] lane_one_offset;
    reg  [31:0] third_offset;
    reg  [31:0] first_lane_ctrl;
    reg  [31:0] second_lane_ctrl;

    // ------------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------------
    wire        first_lane_sign_setting;
    wire        second_lane_sign_setting;
    wire        first_cross_in;
    wire        second_cross_in;
    wire        first_cross_res;
    wire        second_cross_res;
    wire        add_raw;
    wire        blend;
    wire        clamp;
    wire [1:0]  first_force;
    wire [1:0]  second_force;

    assign first_lane_sign_setting  = first_lane_ctrl[`DLI_F_SIGNED];
    assign second_lane_sign_setting = second_lane_ctrl[`DLI_F_SIGNED];
    assign first_cross_in           = first_lane_ctrl[`DLI_F_CROSS_IN];
    assign second_cross_in          = second_lane_ctrl[`DLI_F_CROSS_IN];
    assign first_cross_res          = first_lane_ctrl[`DLI_F_CROSS_RES];
    assign second_cross_res         = second_lane_ctrl[`DLI_F_CROSS_RES];
    assign add_raw                  = first_lane_ctrl[`DLI_F_ADD_RAW];
    assign blend                    = first_lane_ctrl[`DLI_F_BLEND];
    assign clamp = (HAS_CLAMP != 0) ? first_lane_ctrl[`DLI_F_CLAMP] : 1'b0;
    assign first_force  = first_lane_ctrl[`DLI_F_FORCE_HI:`DLI_F_FORCE_LO];
    assign second_force = second_lane_ctrl[`DLI_F_FORCE_HI:`DLI_F_FORCE_LO];

    // ------------------------------------------------------------------
    // lane inputs and shift/mask stages
    // ------------------------------------------------------------------
    wire [31:0] first_in;
    wire [31:0] second_in;
    wire [31:0] first_sm;
    wire [31:0] second_sm;

    assign first_in  = first_cross_in ? lane_one_accumulator : lane_zero_accumulator;
    assign second_in = second_cross_in ? lane_zero_accumulator : lane_one_accumulator;

    // first lane stage
    dli_lane u_first_lane
    (
        .i_data     (first_in),
        .i_shift    (first_lane_ctrl[`DLI_F_SHIFT_HI:`DLI_F_SHIFT_LO]),
        .i_mask_lsb (first_lane_ctrl[`DLI_F_LSB_HI:`DLI_F_LSB_LO]),
        .i_mask_msb (first_lane_ctrl[`DLI_F_MSB_HI:`DLI_F_MSB_LO]),
        .i_signed   (first_lane_sign_setting),
        .o_value    (first_sm)
    );

    // second lane stage
    dli_lane u_second_lane
    (
        .i_data     (second_in),
        .i_shift    (second_lane_ctrl[`DLI_F_SHIFT_HI:`DLI_F_SHIFT_LO]),
        .i_mask_lsb (second_lane_ctrl[`DLI_F_LSB_HI:`DLI_F_LSB_LO]),
        .i_mask_msb (second_lane_ctrl[`DLI_F_MSB_HI:`DLI_F_MSB_LO]),
        .i_signed   (second_lane_sign_setting),
        .o_value    (second_sm)
    );

    // ------------------------------------------------------------------
    // blend arithmetic
    // ------------------------------------------------------------------
    wire signed [33:0] blend_lo;
    wire signed [33:0] blend_hi;
    wire signed [33:0] blend_diff;
    wire signed [9:0]  blend_alpha;
    wire signed [43:0] blend_prod;
    wire        [31:0] blend_value;

    assign blend_lo = second_lane_sign_setting ?
                      {{2{lane_zero_offset[31]}}, lane_zero_offset} :
                      {2'b00, lane_zero_offset};
    assign blend_hi = second_lane_sign_setting ?
                      {{2{lane_one_offset[31]}}, lane_one_offset} :
                      {2'b00, lane_one_offset};
    assign blend_diff  = blend_hi - blend_lo;
    assign blend_alpha = {2'b00, second_sm[7:0]};
    assign blend_prod  = blend_diff * blend_alpha;
    assign blend_value = lane_zero_offset + blend_prod[39:8];

    // ------------------------------------------------------------------
    // clamp comparison
    // ------------------------------------------------------------------
    wire        below_low;
    wire        above_high;
    wire [31:0] clamp_value;

    assign below_low  = first_lane_sign_setting ?
                        ($signed(first_sm) < $signed(lane_zero_offset)) :
                        (first_sm < lane_zero_offset);
    assign above_high = first_lane_sign_setting ?
                        ($signed(first_sm) > $signed(lane_one_offset)) :
                        (first_sm > lane_one_offset);
    assign clamp_value = below_low ? lane_zero_offset :
                         (above_high ? lane_one_offset : first_sm);

    // ------------------------------------------------------------------
    // lane and combined results
    // ------------------------------------------------------------------
    reg  [31:0] first_lane;
    reg  [31:0] second_lane;
    reg  [31:0] full_result;

    // result selection by mode
    always @*
    begin
        first_lane  = first_sm + lane_zero_offset;
        second_lane = second_sm + lane_one_offset;
        full_result = third_offset + first_sm + second_sm;
        if (blend)
        begin
            first_lane  = {24'h000000, second_sm[7:0]};
            second_lane = blend_value;
            full_result = third_offset + first_sm;
        end
        else if (clamp)
        begin
            first_lane = clamp_value;
        end
        else if (add_raw)
        begin
            first_lane = first_in + lane_zero_offset;
        end
    end

    // ------------------------------------------------------------------
    // bus views of the results
    // ------------------------------------------------------------------
    wire [31:0] first_bus;
    wire [31:0] second_bus;

    assign first_bus  = first_lane | {2'b00, first_force, 28'h0000000};
    assign second_bus = second_lane | {2'b00, second_force, 28'h0000000};

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    wire        pop_read;
    wire [31:0] first_half_ext;
    wire [31:0] second_half_ext;

    assign pop_read = i_rd_en &&
                      ((i_addr == `DLI_OFS_POP0) ||
                       (i_addr == `DLI_OFS_POP1) ||
                       (i_addr == `DLI_OFS_POPFULL));

    assign first_half_ext  = first_lane_sign_setting ?
                             {{16{i_wr_data[15]}}, i_wr_data[15:0]} :
                             {16'h0000, i_wr_data[15:0]};
    assign second_half_ext = second_lane_sign_setting ?
                             {{16{i_wr_data[31]}}, i_wr_data[31:16]} :
                             {16'h0000, i_wr_data[31:16]};

    // ------------------------------------------------------------------
    // accumulators
    // ------------------------------------------------------------------
    // accumulator writes, adds and pops
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            lane_zero_accumulator <= `DLI_RST_WORD;
            lane_one_accumulator  <= `DLI_RST_WORD;
        end
        else if (pop_read)
        begin
            lane_zero_accumulator <= first_cross_res ? second_lane : first_lane;
            lane_one_accumulator  <= second_cross_res ? first_lane : second_lane;
        end
        else if (i_wr_en)
        begin
            case (i_addr)
                `DLI_OFS_ACC0:
                begin
                    lane_zero_accumulator <= i_wr_data;
                end
                `DLI_OFS_ACC1:
                begin
                    lane_one_accumulator <= i_wr_data;
                end
                `DLI_OFS_ADD0:
                begin
                    lane_zero_accumulator <= lane_zero_accumulator + i_wr_data;
                end
                `DLI_OFS_ADD1:
                begin
                    lane_one_accumulator <= lane_one_accumulator + i_wr_data;
                end
                default:
                begin
                    lane_zero_accumulator <= lane_zero_accumulator;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // offsets and lane controls
    // ------------------------------------------------------------------
    // configuration writes
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            lane_zero_offset <= `DLI_RST_WORD;
            lane_one_offset  <= `DLI_RST_WORD;
            third_offset     <= `DLI_RST_WORD;
            first_lane_ctrl  <= `DLI_RST_WORD;
            second_lane_ctrl <= `DLI_RST_WORD;
        end
        else if (i_wr_en)
        begin
            case (i_addr)
                `DLI_OFS_LANE_ZERO_OFFSET:
                begin
                    lane_zero_offset <= i_wr_data;
                end
                `DLI_OFS_LANE_ONE_OFFSET:
                begin
                    lane_one_offset <= i_wr_data;
                end
                `DLI_OFS_THIRD_OFFSET:
                begin
                    third_offset <= i_wr_data;
                end
                `DLI_OFS_BASEBOTH:
                begin
                    lane_zero_offset <= first_half_ext;
                    lane_one_offset  <= second_half_ext;
                end
                `DLI_OFS_CTRL0:
                begin
                    first_lane_ctrl <= i_wr_data &
                        ((HAS_CLAMP != 0) ? `DLI_CTRL0_WMASK : `DLI_CTRL0_NOCLAMP);
                end
                `DLI_OFS_CTRL1:
                begin
                    second_lane_ctrl <= i_wr_data & `DLI_CTRL1_WMASK;
                end
                default:
                begin
                    third_offset <= third_offset;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    reg [31:0] next_rd_data;

    // read multiplexer; unmapped reads return zero
    always @*
    begin
        next_rd_data = 32'h00000000;
        if (i_rd_en)
        begin
            case (i_addr)
                `DLI_OFS_ACC0:     next_rd_data = lane_zero_accumulator;
                `DLI_OFS_ACC1:     next_rd_data = lane_one_accumulator;
                `DLI_OFS_LANE_ZERO_OFFSET:    next_rd_data = lane_zero_offset;
                `DLI_OFS_LANE_ONE_OFFSET:    next_rd_data = lane_one_offset;
                `DLI_OFS_THIRD_OFFSET:    next_rd_data = third_offset;
                `DLI_OFS_POP0:     next_rd_data = first_bus;
                `DLI_OFS_POP1:     next_rd_data = second_bus;
                `DLI_OFS_PEEK0:    next_rd_data = first_bus;
                `DLI_OFS_PEEK1:    next_rd_data = second_bus;
                `DLI_OFS_POPFULL:  next_rd_data = full_result;
                `DLI_OFS_PEEKFULL: next_rd_data = full_result;
                `DLI_OFS_CTRL0:    next_rd_data = first_lane_ctrl;
                `DLI_OFS_CTRL1:    next_rd_data = second_lane_ctrl;
                `DLI_OFS_ADD0:     next_rd_data = first_sm;
                `DLI_OFS_ADD1:     next_rd_data = second_sm;
                default:           next_rd_data = 32'h00000000;
            endcase
        end
    end

    // read data stands one cycle after the strobe only
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_rd_data <= `DLI_RST_WORD;
        end
        else
        begin
            o_rd_data <= next_rd_data;
        end
    end

endmodule

// ==== dli_map.vh ====
// register map, field layout and reset values of the dual lane interpolator
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`ifndef DLI_MAP_VH
`define DLI_MAP_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define DLI_ADDR_W          8
`define DLI_OFS_ACC0        8'h00
`define DLI_OFS_ACC1        8'h04
`define DLI_OFS_LANE_ZERO_OFFSET       8'h08
`define DLI_OFS_LANE_ONE_OFFSET       8'h0c
`define DLI_OFS_THIRD_OFFSET       8'h10
`define DLI_OFS_POP0        8'h14
`define DLI_OFS_POP1        8'h18
`define DLI_OFS_POPFULL     8'h1c
`define DLI_OFS_PEEK0       8'h20
`define DLI_OFS_PEEK1       8'h24
`define DLI_OFS_PEEKFULL    8'h28
`define DLI_OFS_CTRL0       8'h2c
`define DLI_OFS_CTRL1       8'h30
`define DLI_OFS_ADD0        8'h34
`define DLI_OFS_ADD1        8'h38
`define DLI_OFS_BASEBOTH    8'h3c

// ------------------------------------------------------------------
// lane control fields
// ------------------------------------------------------------------
`define DLI_F_SHIFT_LO      0
`define DLI_F_SHIFT_HI      4
`define DLI_F_LSB_LO        5
`define DLI_F_LSB_HI        9
`define DLI_F_MSB_LO        10
`define DLI_F_MSB_HI        14
`define DLI_F_SIGNED        15
`define DLI_F_CROSS_IN      16
`define DLI_F_CROSS_RES     17
`define DLI_F_ADD_RAW       18
`define DLI_F_FORCE_LO      19
`define DLI_F_FORCE_HI      20
`define DLI_F_BLEND         21
`define DLI_F_CLAMP         22
`define DLI_CTRL0_WMASK     32'h007fffff
`define DLI_CTRL0_NOCLAMP   32'h003fffff
`define DLI_CTRL1_WMASK     32'h001bffff

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define DLI_RST_WORD        32'h00000000

`endif

// ==== dli_lane.v ====
// shift and mask stage of one interpolator lane
`timescale 1ns/100ps
module dli_lane
(
    input  wire [31:0] i_data,
    input  wire [4:0]  i_shift,
    input  wire [4:0]  i_mask_lsb,
    input  wire [4:0]  i_mask_msb,
    input  wire        i_signed,
    output reg  [31:0] o_value
);

    reg [31:0] shifted;
    reg        sign_bit;
    integer    bit_idx;

    // shift, mask, then optional sign extension above the mask top
    always @*
    begin
        shifted = 32'h00000000;
        sign_bit = 1'b0;
        o_value = 32'h00000000;
        shifted = i_data >> i_shift;
        for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1)
        begin
            if ((bit_idx >= i_mask_lsb) && (bit_idx <= i_mask_msb))
            begin
                o_value[bit_idx] = shifted[bit_idx];
            end
        end
        sign_bit = o_value[i_mask_msb];
        for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1)
        begin
            if (i_signed && (bit_idx > i_mask_msb))
            begin
                o_value[bit_idx] = sign_bit;
            end
        end
    end

endmodule

// ==== dli_checker_assertions.sv ====
// assertion checker of the interpolator register port
`timescale 1ns/100ps
`include "dli_map.vh"
module dli_checker
(
    input wire                   i_ref_clk,
    input wire                   i_reset_n,
    input wire [`DLI_ADDR_W-1:0] i_addr,
    input wire [31:0]            i_wr_data,
    input wire                   i_wr_en,
    input wire                   i_rd_en,
    input wire [31:0]            o_rd_data
);
    // --------
    // strobe decodes
    // --------
    wire wr_both  = i_wr_en && i_addr == `DLI_OFS_BASEBOTH;
    wire rd_acc0  = i_rd_en && i_addr == `DLI_OFS_ACC0;
    wire rd_peek0 = i_rd_en && i_addr == `DLI_OFS_PEEK0;
    wire rd_peek  = i_rd_en && i_addr inside {`DLI_OFS_PEEK0, `DLI_OFS_PEEK1, `DLI_OFS_PEEKFULL};
    wire wr_reg   = i_wr_en && i_addr inside {`DLI_OFS_ACC0, `DLI_OFS_ACC1, `DLI_OFS_LANE_ZERO_OFFSET,
                                              `DLI_OFS_LANE_ONE_OFFSET, `DLI_OFS_THIRD_OFFSET};

    default clocking dcb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    // --------
    // assertions
    // --------
    AST_REG_RDBACK: assert property (
        wr_reg ##1 i_rd_en && i_addr == $past(i_addr) |=> o_rd_data == $past(i_wr_data, 2))
        else $error("read back differs from write");
    AST_BOTH_LOW: assert property (
        wr_both ##1 i_rd_en && i_addr == `DLI_OFS_LANE_ZERO_OFFSET |=> o_rd_data[15:0] == $past(i_wr_data[15:0], 2))
        else $error("low half not loaded into lane zero offset");
    AST_BOTH_HIGH: assert property (
        wr_both ##1 i_rd_en && i_addr == `DLI_OFS_LANE_ONE_OFFSET |=> o_rd_data[15:0] == $past(i_wr_data[31:16], 2))
        else $error("high half not loaded into lane one offset");
    AST_BOTH_SIGN: assert property (
        wr_both ##1 i_rd_en && i_addr inside {`DLI_OFS_LANE_ZERO_OFFSET, `DLI_OFS_LANE_ONE_OFFSET}
        |=> o_rd_data[31:16] == 16'h0000 || o_rd_data[31:16] == {16{o_rd_data[15]}})
        else $error("offset half badly extended");
    AST_PEEK_REPEAT: assert property (
        rd_peek ##1 i_rd_en && i_addr == $past(i_addr) |=> $stable(o_rd_data))
        else $error("peek changed the result");
    AST_PEEK_POP: assert property (
        rd_peek ##1 i_rd_en && i_addr == $past(i_addr) - 8'h0c |=> $stable(o_rd_data))
        else $error("pop result differs from peek");
    AST_ADD_ATOMIC: assert property (
        rd_acc0 ##1 i_wr_en && i_addr == `DLI_OFS_ADD0 ##1 rd_acc0
        |=> o_rd_data == $past(o_rd_data, 2) + $past(i_wr_data, 2))
        else $error("add port sum wrong");
    AST_RO_WRITE: assert property (
        rd_peek0 ##1 i_wr_en && i_addr == `DLI_OFS_PEEK0 ##1 rd_peek0 |=> o_rd_data == $past(o_rd_data, 2))
        else $error("write to result port changed state");

    // main scenarios seen
    cover property (rd_peek ##1 i_rd_en && i_addr == `DLI_OFS_POPFULL);
    cover property (wr_both);
    cover property (i_wr_en && i_addr == `DLI_OFS_ADD0);
endmodule

bind dli_interp dli_checker u_dli_checker
(
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_addr    (i_addr),
    .i_wr_data (i_wr_data),
    .i_wr_en   (i_wr_en),
    .i_rd_en   (i_rd_en),
    .o_rd_data (o_rd_data)
);

// ==== dli_core_model.sv ====
// processor core model driving the interpolator register port
`timescale 1ns/100ps
module dli_core_model
(
    input  wire         i_ref_clk,
    output logic [7:0]  o_addr,
    output logic [31:0] o_wr_data,
    output logic        o_wr_en,
    output logic        o_rd_en,
    input  wire  [31:0] i_rd_data
);
    logic [31:0] rdq[$];
    logic        rd_d;

    // idle bus at time zero
    initial
    begin
        o_addr = 8'h00;
        o_wr_data = 32'h0;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        rd_d = 1'b0;
    end

    // capture read data in the cycle after the strobe
    always @(posedge i_ref_clk)
    begin
        if (rd_d)
            rdq.push_back(i_rd_data);
        rd_d <= o_rd_en;
    end

    // one bus cycle, write or read
    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        o_wr_en <= w;
        o_rd_en <= !w;
        o_addr <= a;
        o_wr_data <= d;
    endtask

    // released bus: strobes low, address and data toggle
    task automatic idle();
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr <= ~o_addr;
        o_wr_data <= ~o_wr_data;
    endtask
endmodule

// ==== dli_interp_bench.sv ====
// self-checking bench of the interpolator with clamp fitted
`timescale 1ns/100ps
module dli_interp_bench;
    logic        i_ref_clk;
    logic        i_reset_n;
    logic [7:0]  i_addr;
    logic [31:0] i_wr_data;
    logic        i_wr_en;
    logic        i_rd_en;
    wire  [31:0] o_rd_data;
    int          fails = 0;
    int          n_checks = 0;
    int          cycles = 0;

    dli_interp #(.HAS_CLAMP(1)) u_dli_interp
    (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_addr    (i_addr),
        .i_wr_data (i_wr_data),
        .i_wr_en   (i_wr_en),
        .i_rd_en   (i_rd_en),
        .o_rd_data (o_rd_data)
    );
    dli_core_model u_dli_core_model
    (
        .i_ref_clk (i_ref_clk),
        .o_addr    (i_addr),
        .o_wr_data (i_wr_data),
        .o_wr_en   (i_wr_en),
        .o_rd_en   (i_rd_en),
        .i_rd_data (o_rd_data)
    );

    // 40 MHz clock
    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    // cut a hung run short
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            stop_test();
        end
    end

    // --------
    // bus and compare helpers
    // --------
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        u_dli_core_model.op(1'b1, a, d);
    endtask
    task automatic r(input logic [7:0] a);
        u_dli_core_model.op(1'b0, a, 32'h0);
    endtask
    task automatic rds(input logic [7:0] a[$]);
        foreach (a[i]) r(a[i]);
    endtask
    task automatic take(output logic [31:0] v);
        repeat (3)
            if (u_dli_core_model.rdq.size() == 0)
                u_dli_core_model.idle();
        v = u_dli_core_model.rdq.pop_front();
    endtask
    task automatic chk(input logic [31:0] exp);
        logic [31:0] got;
        take(got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chks(input logic [31:0] e[$]);
        foreach (e[i]) chk(e[i]);
    endtask
    // ctrl0, ctrl1, acc0, acc1, lane_zero_offset, lane_one_offset, third_offset in turn
    task automatic cfg(input logic [31:0] c0, c1, a0, a1, b0, b1, b2);
        logic [7:0]  ad[7] = '{8'h2c, 8'h30, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
        logic [31:0] v[7];
        v = '{c0, c1, a0, a1, b0, b1, b2};
        foreach (ad[i]) w(ad[i], v[i]);
    endtask

    // --------
    // scenarios
    // --------
    task automatic t_regs();
        logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
        rds('{8'h00, 8'h2c, 8'hfc});
        chks('{32'h0, 32'h0, 32'h0});
        foreach (a[i])
        begin
            w(a[i], 32'h5a000001 + i);
            r(a[i]);
        end
        foreach (a[i]) chk(32'h5a000001 + i);
        $display("test regs done");
    endtask

    task automatic t_shift();
        cfg(32'h82444, 32'h0, 32'habcd, 32'h0, 32'h100, 32'h0, 32'h1000);
        rds('{8'h34, 8'h28, 8'h20, 8'h20, 8'h14, 8'h00, 8'h04});
        chks('{32'h2bc, 32'h12bc, 32'h100003bc, 32'h100003bc, 32'h100003bc, 32'h3bc, 32'h0});
        r(8'h00);
        w(8'h34, 32'h5);
        r(8'h00);
        r(8'h20);
        w(8'h20, 32'hffff);
        r(8'h20);
        chks('{32'h3bc, 32'h3c1, 32'h1000013c, 32'h1000013c});
        $display("test shift done");
    endtask

    task automatic t_sign();
        cfg(32'h0, 32'h9c00, 32'h0, 32'hf0, 32'h0, 32'h0, 32'h0);
        w(8'h3c, 32'hff80ff80);
        r(8'h08);
        w(8'h3c, 32'hff80ff80);
        r(8'h0c);
        r(8'h24);
        chks('{32'hff80, 32'hffffff80, 32'hffffff70});
        $display("test sign done");
    endtask

    task automatic t_blend();
        cfg(32'h200000, 32'h1c00, 32'h1, 32'h40, 32'h100, 32'h200, 32'h1000);
        rds('{8'h20, 8'h24, 8'h28});
        chks('{32'h40, 32'h140, 32'h1001});
        w(8'h30, 32'h9c00);
        w(8'h0c, 32'hffffff00);
        r(8'h24);
        chk(32'h80);
        $display("test blend done");
    endtask

    task automatic t_clamp();
        logic [31:0] av[4] = '{32'h5, 32'h30, 32'h18, 32'hfffffff8};
        cfg(32'h407c00, 32'h0, 32'h0, 32'h0, 32'h10, 32'h20, 32'h0);
        foreach (av[i])
        begin
            w(8'h00, av[i]);
            r(8'h20);
        end
        chks('{32'h10, 32'h20, 32'h18, 32'h20});
        w(8'h2c, 32'h40fc00);
        w(8'h08, 32'hfffffff0);
        r(8'h20);
        chk(32'hfffffff8);
        $display("test clamp done");
    endtask

    task automatic t_cross();
        cfg(32'h57c01, 32'h27c00, 32'h11, 32'h2200, 32'h0, 32'h5, 32'h0);
        rds('{8'h20, 8'h1c, 8'h00, 8'h04});
        chks('{32'h2200, 32'h3300, 32'h2200, 32'h2200});
        $display("test cross done");
    endtask

    task automatic t_save();
        logic [31:0] sv;
        cfg(32'h7c00, 32'h0, 32'h10, 32'h0, 32'h3, 32'h0, 32'h0);
        rds('{8'h14, 8'h00});
        chk(32'h13);
        take(sv);
        w(8'h00, 32'h999);
        w(8'h00, sv);
        r(8'h14);
        chk(32'h16);
        $display("test save done");
    endtask

    // closing report
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reset, then each scenario in turn
    initial
    begin
        i_reset_n = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        t_regs();
        t_shift();
        t_sign();
        t_blend();
        t_clamp();
        t_cross();
        t_save();
        stop_test();
    end
endmodule
